/* hw/rrc_pkg.sv */
// Package of constants and carriers for the radar range counter block
// How it works
// - Range counter steps up or down by range pulses until phase null.
// - Reference square waves come from free counter compared with range counter.
// - Tones nulled in order: 200 cps, then 6.4 kc, then 204.8 kc.
// - Range pulse rate comes from weighted integration of three phase errors.
// - Lock raised after acquisition; interface then flags data valid to computer.
// - Range counter copied into an 18-bit shift register for interface and display.
// - On computer transfer request a 15-bit word loads through a transfer register.
// - Scale switches automatically at threshold: high sends top 15 bits, low bottom.
// - Low-scale discrete tells the computer low scale is in effect.
// - Low-scale bit weight is one eighth of high-scale bit weight.
// - Scale selection is frozen while a word transfer is in progress.
package rrc_pkg;
   localparam int RANGE_W = 18;
   localparam int WORD_W = 15;
   localparam int SCALE_SHIFT = RANGE_W - WORD_W;
   localparam int ERR_W = 8;
   localparam int ACC_W = 20;
   // Register byte offsets
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_RANGE = 12'h008;
   localparam logic [11:0] OFS_WORD = 12'h00C;
   localparam logic [11:0] OFS_THRESH = 12'h010;
   localparam logic [11:0] OFS_WEIGHT = 12'h014;
   localparam logic [11:0] OFS_NULLTOL = 12'h018;
   // Control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_RESTART = 1;
   // Status fields
   localparam int ST_LOCK = 0;
   localparam int ST_LOW = 1;
   localparam int ST_BUSY = 2;
   localparam int ST_TONE = 4;
   // Reset values
   localparam logic [RANGE_W-1:0] THRESH_RST = 18'h08000;
   localparam logic [7:0] WEIGHT_RST = 8'h01;
   localparam logic [ERR_W-1:0] NULLTOL_RST = 8'h02;
   // Free counter bit that each tone's reference uses (coarse to fine)
   localparam int TONE0_BIT = 17;
   localparam int TONE1_BIT = 12;
   localparam int TONE2_BIT = 7;
   // Transfer time in ns, and the whole clock cycles it rounds up to
   localparam int XFER_TIME_NS = 300;
   localparam int CLK_NS = 20;
   localparam int XFER_CYC = (XFER_TIME_NS + CLK_NS - 1) / CLK_NS;
   typedef enum logic [1:0] {
      RRC_TONE_LOW,
      RRC_TONE_MID,
      RRC_TONE_HIGH,
      RRC_TONE_LOCK
   } rrc_tone_e;
   typedef struct packed {
      logic [ERR_W-1:0] err0;
      logic [ERR_W-1:0] err1;
      logic [ERR_W-1:0] err2;
   } rrc_err_s;
   typedef struct packed {
      logic [WORD_W-1:0] word;
      logic low_scale;
      logic valid;
   } rrc_word_s;
endpackage

/* hw/rrc_range_counter.sv */
// Range tracker digital core with APB register slave
`timescale 1ns/1ps
`default_nettype none
module rrc_range_counter #(
   parameter int RANGE_W = rrc_pkg::RANGE_W,
   parameter int WORD_W = rrc_pkg::WORD_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Phase detector errors, signed
   input wire rrc_pkg::rrc_err_s phase_err,
   // Reference square waves
   output logic [2:0] ref_wave,
   // Computer side
   input wire logic xfer_req,
   output rrc_pkg::rrc_word_s range_word,
   output logic xfer_busy,
   output logic range_lock,
   // Display shift register
   output logic [RANGE_W-1:0] display_range
);
   // Scale logic serves only the default widths
   if (RANGE_W != rrc_pkg::RANGE_W || WORD_W != rrc_pkg::WORD_W) begin
      $error("rrc_range_counter: widths fixed by scale logic");
   end

   function automatic logic near_null(input logic [rrc_pkg::ERR_W-1:0] e,
                                      input logic [rrc_pkg::ERR_W-1:0] tol);
      logic [rrc_pkg::ERR_W-1:0] mag;
      mag = e[rrc_pkg::ERR_W-1] ? (~e + 8'h01) : e;
      return mag <= tol;
   endfunction

   function automatic logic [rrc_pkg::ACC_W-1:0] sext(input logic [rrc_pkg::ERR_W-1:0] e);
      return {{(rrc_pkg::ACC_W - rrc_pkg::ERR_W){e[rrc_pkg::ERR_W-1]}}, e};
   endfunction

   // State
   logic enable_reg, enable_next;
   logic [RANGE_W-1:0] thresh_reg, thresh_next;
   logic [7:0] weight_reg, weight_next;
   logic [rrc_pkg::ERR_W-1:0] tol_reg, tol_next;
   logic [RANGE_W-1:0] free_reg, free_next;
   logic [RANGE_W-1:0] range_reg, range_next;
   logic [rrc_pkg::ACC_W-1:0] acc_reg, acc_next;
   logic [rrc_pkg::ACC_W-1:0] rate_reg, rate_next;
   rrc_pkg::rrc_tone_e tone_reg, tone_next;
   logic [RANGE_W-1:0] shift_reg, shift_next;
   logic low_reg, low_next;
   logic [4:0] xcnt_reg, xcnt_next;
   rrc_pkg::rrc_word_s word_reg, word_next;
   logic [31:0] rdata_reg, rdata_next;
   logic restart;
   logic wr_en;
   logic rd_en;
   logic mapped;
   logic [rrc_pkg::ERR_W-1:0] cur_err;
   logic [rrc_pkg::ACC_W-1:0] werr;
   logic [rrc_pkg::ACC_W-1:0] step;
   logic pulse;
   logic up;

   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;
   assign mapped = paddr <= rrc_pkg::OFS_NULLTOL && paddr[1:0] == 2'b00;
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
   assign prdata = rdata_reg;
   assign restart = wr_en && paddr == rrc_pkg::OFS_CTRL && pstrb[0]
                    && pwdata[rrc_pkg::CTRL_RESTART];

   // Register writes and read data
   always_comb begin
      enable_next = enable_reg;
      thresh_next = thresh_reg;
      weight_next = weight_reg;
      tol_next = tol_reg;
      rdata_next = rdata_reg;
      if (wr_en && pstrb[0]) begin
         case (paddr)
            rrc_pkg::OFS_CTRL: enable_next = pwdata[rrc_pkg::CTRL_ENABLE];
            rrc_pkg::OFS_THRESH: thresh_next[7:0] = pwdata[7:0];
            rrc_pkg::OFS_WEIGHT: weight_next = pwdata[7:0];
            rrc_pkg::OFS_NULLTOL: tol_next = pwdata[rrc_pkg::ERR_W-1:0];
            default: ;
         endcase
      end
      if (wr_en && paddr == rrc_pkg::OFS_THRESH && pstrb[1]) begin
         thresh_next[15:8] = pwdata[15:8];
      end
      if (wr_en && paddr == rrc_pkg::OFS_THRESH && pstrb[2]) begin
         thresh_next[RANGE_W-1:16] = pwdata[RANGE_W-1:16];
      end
      if (rd_en) begin
         case (paddr)
            rrc_pkg::OFS_CTRL: rdata_next = {31'h00000000, enable_reg};
            rrc_pkg::OFS_STATUS: rdata_next = {26'h0000000, tone_reg, 1'b0,
                                               xfer_busy, low_reg, range_lock};
            rrc_pkg::OFS_RANGE: rdata_next = {14'h0000, shift_reg};
            rrc_pkg::OFS_WORD: rdata_next = {17'h00000, word_reg.word};
            rrc_pkg::OFS_THRESH: rdata_next = {14'h0000, thresh_reg};
            rrc_pkg::OFS_WEIGHT: rdata_next = {24'h000000, weight_reg};
            rrc_pkg::OFS_NULLTOL: rdata_next = {24'h000000, tol_reg};
            default: rdata_next = 32'h00000000;
         endcase
      end
   end

   // Select error of tone being acquired
   always_comb begin
      case (tone_reg)
         rrc_pkg::RRC_TONE_LOW: cur_err = phase_err.err0;
         rrc_pkg::RRC_TONE_MID: cur_err = phase_err.err1;
         default: cur_err = phase_err.err2;
      endcase
   end

   // Weighted sum of the three errors, current tone weighted most
   always_comb begin
      werr = sext(phase_err.err0) + sext(phase_err.err1) + sext(phase_err.err2)
             + ((sext(cur_err) * {12'h000, weight_reg}) & 20'hFFFFF);
   end

   // Integrator drives pulse rate accumulator
   always_comb begin
      acc_next = acc_reg;
      rate_next = rate_reg;
      pulse = 1'b0;
      up = !acc_reg[rrc_pkg::ACC_W-1];
      step = acc_reg[rrc_pkg::ACC_W-1] ? (~acc_reg + 20'h00001) : acc_reg;
      if (restart || !enable_reg) begin
         acc_next = 20'h00000;
         rate_next = 20'h00000;
      end else begin
         acc_next = acc_reg + werr;
         {pulse, rate_next} = {1'b0, rate_reg} + {1'b0, step};
      end
   end

   // Range counter, free counter and tone sequence
   always_comb begin
      free_next = free_reg + 18'h00001;
      range_next = range_reg;
      tone_next = tone_reg;
      if (restart || !enable_reg) begin
         tone_next = rrc_pkg::RRC_TONE_LOW;
      end else begin
         if (pulse) begin
            range_next = up ? range_reg + 18'h00001 : range_reg - 18'h00001;
         end
         if (near_null(cur_err, tol_reg)) begin
            case (tone_reg)
               rrc_pkg::RRC_TONE_LOW: tone_next = rrc_pkg::RRC_TONE_MID;
               rrc_pkg::RRC_TONE_MID: tone_next = rrc_pkg::RRC_TONE_HIGH;
               rrc_pkg::RRC_TONE_HIGH: tone_next = rrc_pkg::RRC_TONE_LOCK;
               default: tone_next = rrc_pkg::RRC_TONE_LOCK;
            endcase
         end else if (tone_reg == rrc_pkg::RRC_TONE_LOCK) begin
            tone_next = rrc_pkg::RRC_TONE_HIGH;
         end
      end
   end

   // Reference phase follows range count
   always_comb begin
      logic [RANGE_W-1:0] diff;
      diff = free_reg - range_reg;
      ref_wave = {diff[rrc_pkg::TONE2_BIT], diff[rrc_pkg::TONE1_BIT],
                  diff[rrc_pkg::TONE0_BIT]};
   end

   // Shift register copy, scale logic and transfer
   always_comb begin
      shift_next = range_reg;
      low_next = low_reg;
      xcnt_next = xcnt_reg;
      word_next = word_reg;
      word_next.low_scale = low_reg;
      word_next.valid = range_lock;
      if (xcnt_reg == 5'h00) begin
         if (xfer_req) begin
            // Scale held from the take edge so flag and word agree
            xcnt_next = 5'(rrc_pkg::XFER_CYC);
            word_next.word = low_reg ? shift_reg[WORD_W-1:0]
                             : shift_reg[RANGE_W-1:rrc_pkg::SCALE_SHIFT];
         end else begin
            low_next = shift_reg < thresh_reg;
         end
      end else begin
         xcnt_next = xcnt_reg - 5'h01;
      end
   end

   assign range_lock = tone_reg == rrc_pkg::RRC_TONE_LOCK;
   assign xfer_busy = xcnt_reg != 5'h00;
   assign range_word = word_reg;
   assign display_range = shift_reg;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_reg <= 1'b0;
         thresh_reg <= rrc_pkg::THRESH_RST;
         weight_reg <= rrc_pkg::WEIGHT_RST;
         tol_reg <= rrc_pkg::NULLTOL_RST;
         rdata_reg <= 32'h00000000;
         free_reg <= 18'h00000;
         range_reg <= 18'h00000;
         acc_reg <= 20'h00000;
         rate_reg <= 20'h00000;
         tone_reg <= rrc_pkg::RRC_TONE_LOW;
         shift_reg <= 18'h00000;
         low_reg <= 1'b1;
         xcnt_reg <= 5'h00;
         word_reg <= '0;
      end else begin
         enable_reg <= enable_next;
         thresh_reg <= thresh_next;
         weight_reg <= weight_next;
         tol_reg <= tol_next;
         rdata_reg <= rdata_next;
         free_reg <= free_next;
         range_reg <= range_next;
         acc_reg <= acc_next;
         rate_reg <= rate_next;
         tone_reg <= tone_next;
         shift_reg <= shift_next;
         low_reg <= low_next;
         xcnt_reg <= xcnt_next;
         word_reg <= word_next;
      end
   end
endmodule
`default_nettype wire

/* bench/rrc_range_counter_properties.sv */
// Port checker for the range counter
`timescale 1ns/1ps
`default_nettype none
module rrc_range_counter_properties #(
   parameter int RANGE_W = rrc_pkg::RANGE_W,
   parameter int WORD_W = rrc_pkg::WORD_W
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bus and computer side
   input wire logic psel,
   input wire logic penable,
   input wire logic [11:0] paddr,
   input wire logic pslverr,
   input wire logic xfer_req,
   input wire logic xfer_busy,
   input wire logic range_lock,
   input wire rrc_pkg::rrc_word_s range_word,
   input wire logic [RANGE_W-1:0] display_range
);
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_step_single: assert property (!$stable(display_range) |->
      display_range - $past(display_range) inside {RANGE_W'(1), {RANGE_W{1'b1}}})
      else $error("range moved more than one step");
   a_req_taken: assert property (xfer_req && !xfer_busy |=> xfer_busy)
      else $error("request not taken");
   a_busy_len: assert property ($rose(xfer_busy) |->
      xfer_busy[*8] ##1 xfer_busy[*7] ##1 !xfer_busy) else $error("busy length wrong");
   a_word_held: assert property (xfer_busy ##1 xfer_busy |-> $stable(range_word.word))
      else $error("word moved during transfer");
   a_scale_frozen: assert property (xfer_busy ##1 xfer_busy |->
      $stable(range_word.low_scale)) else $error("scale changed during transfer");
   a_word_pick: assert property ($rose(xfer_busy) && $stable(display_range) |->
      range_word.word == (range_word.low_scale ? display_range[WORD_W-1:0] :
      display_range[RANGE_W-1:RANGE_W-WORD_W])) else $error("word bits wrong");
   a_valid_lock: assert property (range_word.valid == $past(range_lock))
      else $error("valid does not follow lock");
   a_bad_addr: assert property (psel && penable && paddr > rrc_pkg::OFS_NULLTOL |-> pslverr)
      else $error("no error on unmapped address");
endmodule
bind rrc_range_counter rrc_range_counter_properties #(.RANGE_W(RANGE_W), .WORD_W(WORD_W))
   u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .pslverr(pslverr), .xfer_req(xfer_req), .xfer_busy(xfer_busy), .range_lock(range_lock),
   .range_word(range_word), .display_range(display_range));
`default_nettype wire

/* bench/rrc_computer_model.sv */
// Guidance computer model fetching range words
`timescale 1ns/1ps
`default_nettype none
module rrc_computer_model (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // Bench command and range link
   input wire logic fetch,
   input wire logic xfer_busy,
   input wire rrc_pkg::rrc_word_s range_word,
   output logic xfer_req,
   output rrc_pkg::rrc_word_s got,
   output logic got_done
);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         xfer_req <= 1'b0;
         got <= '0;
         got_done <= 1'b0;
      end else begin
         got_done <= xfer_req && xfer_busy;
         if (xfer_req && xfer_busy) begin
            xfer_req <= 1'b0;
            got <= range_word;
         end else if (fetch && !xfer_busy) begin
            xfer_req <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* bench/test_rrc_range_counter.sv */
// Self-checking bench for the range counter block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin error_cnt++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module test_rrc_range_counter;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, fetch = 0;
   logic pready, pslverr, er, xfer_req, xfer_busy, range_lock, got_done;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [2:0] ref_wave;
   logic [17:0] display_range, rng;
   rrc_pkg::rrc_err_s phase_err = '0;
   rrc_pkg::rrc_word_s range_word, got;
   int error_cnt = 0, n_compared = 0;
   initial forever #10 pclk = ~pclk;
   rrc_range_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .phase_err(phase_err), .ref_wave(ref_wave),
      .xfer_req(xfer_req), .range_word(range_word), .xfer_busy(xfer_busy),
      .range_lock(range_lock), .display_range(display_range));
   rrc_computer_model gc (.pclk(pclk), .presetn(presetn), .fetch(fetch),
      .xfer_busy(xfer_busy), .range_word(range_word), .xfer_req(xfer_req), .got(got),
      .got_done(got_done));
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic st(input logic [2:0] e);
      apb(1'b0, rrc_pkg::OFS_STATUS, 32'h0);
      `CHK({rd[5:4], rd[0]}, e)
   endtask
   task automatic wlock;
      for (int i = 0; i < 50 && range_lock !== 1'b1; i++) @(posedge pclk);
   endtask
   task automatic t_map;
      apb(1'b0, rrc_pkg::OFS_THRESH, 32'h0);
      `CHK(rd, 32'h00008000)
      apb(1'b0, 12'h01C, 32'h0);
      `CHK({er, rd}, 33'h100000000)
      $display("map test done");
   endtask
   task automatic t_tones;
      phase_err <= {8'h00, 8'h40, 8'h00};
      apb(1'b1, rrc_pkg::OFS_CTRL, 32'h1);
      repeat (10) @(posedge pclk);
      st(3'b010);
      phase_err <= {8'h00, 8'h00, 8'h40};
      repeat (3000) @(posedge pclk);
      st(3'b100);
      apb(1'b0, rrc_pkg::OFS_RANGE, 32'h0);
      `CHK(rd[17:0] > 18'h00000 && rd[17:0] < 18'h20000, 1'b1)
      phase_err <= '0;
      wlock();
      st(3'b111);
      apb(1'b1, rrc_pkg::OFS_CTRL, 32'h3);
      wlock();
      st(3'b111);
      $display("tone test done");
   endtask
   task automatic t_ref;
      logic prev;
      int n;
      @(posedge pclk);
      prev = ref_wave[2];
      for (n = 0; n < 300 && ref_wave[2] === prev; n++) @(posedge pclk);
      prev = ref_wave[2];
      for (n = 0; n < 300 && ref_wave[2] === prev; n++) @(posedge pclk);
      `CHK(n, 1 << rrc_pkg::TONE2_BIT)
      $display("reference test done");
   endtask
   task automatic t_scale;
      apb(1'b0, rrc_pkg::OFS_RANGE, 32'h0);
      rng = rd[17:0];
      `CHK(display_range, rng)
      for (int k = 0; k < 2; k++) begin
         apb(1'b1, rrc_pkg::OFS_THRESH, {14'h0, rng + 18'(1 - k)});
         fetch <= 1'b1;
         for (int i = 0; i < 40 && got_done !== 1'b1; i++) @(posedge pclk);
         fetch <= 1'b0;
         `CHK(got.low_scale, k == 0)
         `CHK(got.word, (k == 0) ? rng[14:0] : rng[17:3])
         `CHK(got.valid, 1'b1)
         repeat (20) @(posedge pclk);
      end
      $display("scale test done");
   endtask
   task close_out;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_map();
      t_tones();
      t_ref();
      t_scale();
      close_out();
   end
   initial begin
      repeat (20000) @(posedge pclk);
      error_cnt++;
      close_out();
   end
endmodule
`default_nettype wire
